// [shared/i2cw_pkg.sv]
// Constants and types shared by the sideband register write port.
package i2cw_pkg;

  // Address byte: bit 6 fixed low, bits 5:3 fixed high, bits 2:0 from select pins.
  localparam logic [3:0] ADDR_FIXED = 4'h7;
  localparam logic DIR_WRITE = 1'h0;

  // Command byte 0 fields.
  localparam int OP_MSB = 2;
  localparam logic [2:0] OP_WRITE = 3'h3;

  // Command byte 1 and 2 fields.
  localparam int PSEL_HI_BIT = 0;
  localparam int PSEL_LO_BIT = 7;
  localparam int BE_MSB = 5;
  localparam int BE_LSB = 2;
  localparam int AHI_MSB = 1;
  localparam logic [1:0] PORT_MAX = 2'h2;

  // Register space.
  localparam int N_PORTS = 3;
  localparam int N_DWORDS = 1024;
  localparam int AW = 12;
  localparam int DWW = 10;
  localparam logic [1:0] ADDR_LOW = 2'h0;

  // Bit and byte counting on the link.
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] CNT_FIRST = 4'h1;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [1:0] IDX_LAST = 2'h3;
  localparam logic [1:0] IDX_RST = 2'h0;

  // Reset values.
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [3:0] BE_RST = 4'h0;
  localparam logic [1:0] PORT_RST = 2'h0;
  localparam logic [AW-1:0] WADDR_RST = 12'h000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_CMD = 5'h04,
    ST_DATA = 5'h08,
    ST_XTRA = 5'h10
  } i2cw_state_t;

endpackage

// [tb/i2cw_host.sv]
// Behavioural I2C bus master that drives the link side of the write port.
module i2cw_host (
  // Link pins; sda_drv high pulls the data line low.
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'h1;
    sda_drv = 1'h0;
  end

  // The slave resets its link side on clock edges, and its start detector needs a data
  // fall with the clock low after that reset has settled, so the fall follows four clocks.
  task automatic bus_reset();
    scl = 1'h0;
    sda_drv = 1'h0;
    repeat (4) begin
      #80 scl = 1'h1;
      #80 scl = 1'h0;
    end
    #40 sda_drv = 1'h1;
    #40 scl = 1'h1;
    #80 scl = 1'h0;
    #40 sda_drv = 1'h0;
    #40 scl = 1'h1;
    #80;
  endtask

  task automatic start();
    if (scl === 1'h0) begin
      sda_drv = 1'h0;
      #40 scl = 1'h1;
    end
    #40 sda_drv = 1'h1;
    #40 scl = 1'h0;
    #40;
  endtask

  task automatic stop();
    sda_drv = 1'h1;
    #40 scl = 1'h1;
    #40 sda_drv = 1'h0;
    #80;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = ~b[i];
      #40 scl = 1'h1;
      #80 scl = 1'h0;
      #40;
    end
    // The line is let go so the answer reads high by pull-up unless the slave pulls it.
    sda_drv = 1'h0;
    #40 scl = 1'h1;
    #40 nack = sda;
    #40 scl = 1'h0;
    #40;
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the sideband register write port.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, host_scl, host_drv, scl_out, scl_oe, sda_out, sda_oe;
  logic scl_line, sda_line, wr_stb, bad_cmd;
  logic [2:0] addr_sel;
  logic [1:0] rd_port, wr_port, p;
  logic [i2cw_pkg::DWW-1:0] rd_addr, a;
  logic [31:0] rd_data, wr_data;
  logic [i2cw_pkg::AW-1:0] wr_addr;
  logic [3:0] wr_be;
  logic [7:0] good;
  int fail_count, cmp_count, stb_n, bad_n, s0, b0;
  int unsigned mem [int];

  assign scl_line = (scl_oe && !scl_out) ? 1'h0 : host_scl;
  assign sda_line = (host_drv || (sda_oe && !sda_out)) ? 1'h0 : 1'h1;

  i2cw_host m_host (.scl(host_scl), .sda_drv(host_drv), .sda(sda_line));
  i2cw_slave i_i2cw_slave (.ref_clk(ref_clk), .rst(rst), .scl_clk(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .rd_port(rd_port), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_stb(wr_stb), .wr_port(wr_port), .wr_addr(wr_addr),
    .wr_be(wr_be), .wr_data(wr_data), .bad_cmd(bad_cmd));

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (wr_stb === 1'h1) stb_n++;
    if (bad_cmd === 1'h1) bad_n++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // address, four command bytes, then the data bytes.
  task automatic frame(input logic [7:0] ab, input logic [31:0] cmd, input logic [39:0] dat,
                       input int n, input bit ok, input bit rs);
    logic nack;
    logic [79:0] all;
    all = {ab, cmd, dat};
    m_host.start();
    for (int i = 0; i < 5 + n; i++) begin
      m_host.put_byte(all[79 - 8 * i -: 8], nack);
      check(nack, !(ok && i < 9));
    end
    if (!rs) begin
      m_host.stop();
    end
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic rd(input logic [1:0] rp, input logic [9:0] ra, input logic [31:0] exp);
    rd_port = rp;
    rd_addr = ra;
    repeat (2) @(negedge ref_clk);
    check(rd_data, exp);
  endtask

  task automatic do_write(input logic [3:0] be, input logic [31:0] d, input int n,
                          input bit rs);
    int key;
    int unsigned v;
    s0 = stb_n;
    key = p * 1024 + a;
    v = mem.exists(key) ? mem[key] : 0;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) v[8 * k +: 8] = d[8 * k +: 8];
    end
    mem[key] = v;
    // reserved command bits carry random values, except command byte 1 bits 5:1, which are zero.
    frame(good, {5'($urandom), i2cw_pkg::OP_WRITE, 2'($urandom), 5'h00, p, 1'($urandom),
          be, a}, {d, 8'($urandom)}, n, 1, rs);
    check(stb_n - s0, 1);
    check({wr_port, wr_be, wr_addr}, {p, be, a, 2'h0});
    check(wr_data, d);
    rd(p, a, v);
  endtask

  initial begin
    rst = 1'h1;
    rd_port = 2'h0;
    rd_addr = '0;
    addr_sel = 3'h0;
    void'($urandom(45));
    @(negedge ref_clk);
    addr_sel = 3'($urandom);
    // Reset is held longer than four cycles so the link side sees enough clock edges.
    fork
      begin
        #13;
        m_host.bus_reset();
      end
      repeat (8) @(negedge ref_clk);
    join
    @(negedge ref_clk);
    check({wr_stb, bad_cmd, sda_oe, scl_oe, scl_out, sda_out}, 0);
    check({wr_port, wr_be, wr_addr}, 0);
    check(wr_data, 0);
    check(rd_data, 0);
    rst = 1'h0;
    // The link side leaves reset only on its own clock edges, so it is clocked once more.
    m_host.bus_reset();
    good = {i2cw_pkg::ADDR_FIXED, addr_sel, i2cw_pkg::DIR_WRITE};
    // full write, then a lane merge with random enables.
    for (int k = 0; k < 6; k++) begin
      p = 2'($urandom_range(2));
      a = 10'($urandom);
      do_write(4'hf, $urandom, 4, 0);
      do_write(4'($urandom), $urandom, 4 + (k == 5), k[0]);
    end
    // every other opcode, and port three.
    for (int op = 0; op < 8; op++) begin
      s0 = stb_n;
      b0 = bad_n;
      frame(good, {5'h00, 3'(op), 7'h00, op == 3 ? 2'h3 : p, 1'h0, 4'hf, a},
            {32'($urandom), 8'h00}, 4, 1, 0);
      check(stb_n - s0, 0);
      check(bad_n - b0, 1);
      rd(p, a, mem[p * 1024 + a]);
    end
    // foreign address, read direction, fixed bit set, short frame.
    for (int j = 0; j < 4; j++) begin
      s0 = stb_n;
      b0 = bad_n;
      frame(j == 0 ? good ^ 8'h02 : j == 1 ? good | 8'h01 : j == 2 ? good ^ 8'h80 : good,
            {8'h03, 8'h00, 8'h3c, a[7:0]}, 40'($urandom), j == 3 ? 3 : 4, j == 3, 0);
      check(stb_n + bad_n - s0 - b0, 0);
    end
    close_out();
  end

  initial begin
    #1_000_000;
    fail_count++;
    close_out();
  end
endmodule

// [verilog/i2cw_slave.sv]
// Sideband I2C slave that writes 32-bit configuration registers of three ports.
module i2cw_slave (
  // System clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Link clock and data pins.
  input wire logic scl_clk,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address select straps.
  input wire logic [2:0] addr_sel,
  // Register read port for the rest of the switch.
  input wire logic [1:0] rd_port,
  input wire logic [i2cw_pkg::DWW-1:0] rd_addr,
  output logic [31:0] rd_data,
  // Write notification.
  output logic wr_stb,
  output logic [1:0] wr_port,
  output logic [i2cw_pkg::AW-1:0] wr_addr,
  output logic [3:0] wr_be,
  output logic [31:0] wr_data,
  output logic bad_cmd
);

  // Link domain signals.
  logic rst_l;
  logic [2:0] sel_l;
  logic start_q;
  logic start_seen_q;
  logic new_frame;
  i2cw_pkg::i2cw_state_t st_q;
  logic [3:0] cnt_q;
  logic [1:0] idx_q;
  logic [6:0] sh_q;
  logic [7:0] rx_byte;
  logic byte_done;
  logic ack_d;
  logic ack_q;
  logic last_q;
  logic oe_q;
  logic [7:0] cmd_q [0:3];
  logic [7:0] dat_q [0:3];
  logic [1:0] port_sel;
  logic cmd_ok;
  logic cmt_tgl_q;
  logic bad_tgl_q;
  logic [1:0] h_port_q;
  logic [3:0] h_be_q;
  logic [i2cw_pkg::AW-1:0] h_addr_q;
  logic [31:0] h_data_q;

  // System domain signals.
  logic [1:0] tgl_s;
  logic [1:0] tgl_prev_q;
  logic cmt_evt;
  logic bad_evt;
  logic wr_stb_q;
  logic bad_q;
  logic [1:0] wr_port_q;
  logic [i2cw_pkg::AW-1:0] wr_addr_q;
  logic [3:0] wr_be_q;
  logic [31:0] wr_data_q;
  logic [31:0] rd_data_q;
  logic [31:0] cfg_mem [0:i2cw_pkg::N_PORTS-1][0:i2cw_pkg::N_DWORDS-1];

  // The reset and the straps enter the link domain through synchronisers, so the
  // link clock must run a few edges while reset is held and again after release.
  i2cw_sync #(.W(4)) u_link_sync (
    .clk(scl_clk),
    .d({rst, addr_sel}),
    .sync_q({rst_l, sel_l})
  );

  // start detection.
  // A falling data line with the clock high marks a START; any later fall with the
  // clock low, such as our own acknowledge, clears it again.
  always_ff @(negedge sda_in) begin
    if (rst_l) begin
      start_q <= 1'b0;
    end else begin
      start_q <= scl_clk;
    end
  end

  always_ff @(posedge scl_clk) begin
    if (rst_l) begin
      start_seen_q <= 1'b0;
    end else begin
      start_seen_q <= start_q;
    end
  end

  assign new_frame = start_q & ~start_seen_q;
  assign rx_byte = {sh_q, sda_in};
  assign byte_done = (st_q != i2cw_pkg::ST_IDLE) && (cnt_q == i2cw_pkg::BIT_LAST) && !new_frame;

  always_comb begin
    case (st_q)
      i2cw_pkg::ST_ADDR: ack_d = (rx_byte[7:1] == {i2cw_pkg::ADDR_FIXED, sel_l}) &&
                                 (rx_byte[0] == i2cw_pkg::DIR_WRITE);
      i2cw_pkg::ST_CMD: ack_d = 1'b1;
      i2cw_pkg::ST_DATA: ack_d = 1'b1;
      i2cw_pkg::ST_XTRA: ack_d = 1'b0;
      default: ack_d = 1'b0;
    endcase
  end

  always_ff @(posedge scl_clk) begin
    if (rst_l) begin
      st_q <= i2cw_pkg::ST_IDLE;
      idx_q <= i2cw_pkg::IDX_RST;
    end else if (new_frame) begin
      st_q <= i2cw_pkg::ST_ADDR;
      idx_q <= i2cw_pkg::IDX_RST;
    end else if (byte_done) begin
      case (st_q)
        i2cw_pkg::ST_ADDR: begin
          st_q <= ack_d ? i2cw_pkg::ST_CMD : i2cw_pkg::ST_IDLE;
        end
        i2cw_pkg::ST_CMD: begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == i2cw_pkg::IDX_LAST) begin
            st_q <= i2cw_pkg::ST_DATA;
          end
        end
        i2cw_pkg::ST_DATA: begin
          idx_q <= idx_q + 2'h1;
          if (idx_q == i2cw_pkg::IDX_LAST) begin
            st_q <= i2cw_pkg::ST_XTRA;
          end
        end
        i2cw_pkg::ST_XTRA: st_q <= i2cw_pkg::ST_XTRA;
        default: st_q <= i2cw_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge scl_clk) begin
    if (rst_l) begin
      cnt_q <= i2cw_pkg::CNT_RST;
      sh_q <= 7'h00;
      ack_q <= 1'b0;
    end else if (new_frame) begin
      cnt_q <= i2cw_pkg::CNT_FIRST;
      sh_q <= {6'h00, sda_in};
      ack_q <= 1'b0;
    end else if (st_q != i2cw_pkg::ST_IDLE) begin
      cnt_q <= (cnt_q == i2cw_pkg::ACK_SLOT) ? i2cw_pkg::CNT_RST : cnt_q + 4'h1;
      if (cnt_q != i2cw_pkg::ACK_SLOT) begin
        sh_q <= rx_byte[6:0];
      end
      if (byte_done) begin
        ack_q <= ack_d;
      end
    end else begin
      ack_q <= 1'b0;
    end
  end

  // Command and data bytes are kept as received.
  always_ff @(posedge scl_clk) begin
    if (rst_l) begin
      for (int i = 0; i < 4; i++) begin
        cmd_q[i] <= i2cw_pkg::BYTE_RST;
        dat_q[i] <= i2cw_pkg::BYTE_RST;
      end
    end else if (byte_done && st_q == i2cw_pkg::ST_CMD) begin
      cmd_q[idx_q] <= rx_byte;
    end else if (byte_done && st_q == i2cw_pkg::ST_DATA) begin
      dat_q[idx_q] <= rx_byte;
    end
  end

  // port select from the two split bits, reserved bits unused.
  assign port_sel = {cmd_q[1][i2cw_pkg::PSEL_HI_BIT], cmd_q[2][i2cw_pkg::PSEL_LO_BIT]};
  assign cmd_ok = (cmd_q[0][i2cw_pkg::OP_MSB:0] == i2cw_pkg::OP_WRITE) &&
                  (port_sel <= i2cw_pkg::PORT_MAX);

  // commit at the fourth data acknowledge, on its rising clock edge.
  // The held word stays put for a whole frame, far longer than the system side
  // needs to pick it up after the toggle crosses over.
  always_ff @(posedge scl_clk) begin
    if (rst_l) begin
      last_q <= 1'b0;
      cmt_tgl_q <= 1'b0;
      bad_tgl_q <= 1'b0;
      h_port_q <= i2cw_pkg::PORT_RST;
      h_be_q <= i2cw_pkg::BE_RST;
      h_addr_q <= i2cw_pkg::WADDR_RST;
      h_data_q <= i2cw_pkg::WORD_RST;
    end else if (new_frame) begin
      last_q <= 1'b0;
    end else if (byte_done && st_q == i2cw_pkg::ST_DATA && idx_q == i2cw_pkg::IDX_LAST) begin
      last_q <= 1'b1;
    end else if (last_q && cnt_q == i2cw_pkg::ACK_SLOT) begin
      last_q <= 1'b0;
      // invalid command raises only the error event.
      if (cmd_ok) begin
        cmt_tgl_q <= ~cmt_tgl_q;
        h_port_q <= port_sel;
        h_be_q <= cmd_q[2][i2cw_pkg::BE_MSB:i2cw_pkg::BE_LSB];
        h_addr_q <= {cmd_q[2][i2cw_pkg::AHI_MSB:0], cmd_q[3], i2cw_pkg::ADDR_LOW};
        // first data byte is the most significant.
        h_data_q <= {dat_q[0], dat_q[1], dat_q[2], dat_q[3]};
      end else begin
        bad_tgl_q <= ~bad_tgl_q;
      end
    end
  end

  // drive the acknowledge while the clock is low.
  always_ff @(negedge scl_clk) begin
    if (rst_l) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ack_q && (cnt_q == i2cw_pkg::ACK_SLOT);
    end
  end

  // Clock stretching is not used, so the clock pin is never driven.
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // Events cross as toggles; edges are taken after the second flop.
  i2cw_sync #(.W(2)) u_evt_sync (
    .clk(ref_clk),
    .d({cmt_tgl_q, bad_tgl_q}),
    .sync_q(tgl_s)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgl_prev_q <= 2'h0;
    end else begin
      tgl_prev_q <= tgl_s;
    end
  end

  assign cmt_evt = tgl_s[1] ^ tgl_prev_q[1];
  assign bad_evt = tgl_s[0] ^ tgl_prev_q[0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_stb_q <= 1'b0;
      bad_q <= 1'b0;
      wr_port_q <= i2cw_pkg::PORT_RST;
      wr_addr_q <= i2cw_pkg::WADDR_RST;
      wr_be_q <= i2cw_pkg::BE_RST;
      wr_data_q <= i2cw_pkg::WORD_RST;
    end else begin
      wr_stb_q <= cmt_evt;
      bad_q <= bad_evt;
      if (cmt_evt) begin
        wr_port_q <= h_port_q;
        wr_addr_q <= h_addr_q;
        wr_be_q <= h_be_q;
        wr_data_q <= h_data_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (cmt_evt) begin
      for (int b = 0; b < 4; b++) begin
        if (h_be_q[b]) begin
          cfg_mem[h_port_q][h_addr_q[i2cw_pkg::AW-1:2]][b*8 +: 8] <= h_data_q[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_q <= i2cw_pkg::WORD_RST;
    end else if (rd_port <= i2cw_pkg::PORT_MAX) begin
      rd_data_q <= cfg_mem[rd_port][rd_addr];
    end else begin
      rd_data_q <= i2cw_pkg::WORD_RST;
    end
  end

  assign rd_data = rd_data_q;
  assign wr_stb = wr_stb_q;
  assign bad_cmd = bad_q;
  assign wr_port = wr_port_q;
  assign wr_addr = wr_addr_q;
  assign wr_be = wr_be_q;
  assign wr_data = wr_data_q;

  addr_ack_a: assert property (@(posedge scl_clk) disable iff (rst_l)
    (st_q == i2cw_pkg::ST_ADDR && byte_done && sda_in == 1'b0 &&
     sh_q == {i2cw_pkg::ADDR_FIXED, sel_l}) |=> ack_q ##0 (st_q == i2cw_pkg::ST_CMD))
    else $error("Matching write address was not acknowledged.");

  read_nack_a: assert property (@(posedge scl_clk) disable iff (rst_l)
    (st_q == i2cw_pkg::ST_ADDR && byte_done && sda_in == 1'b1) |=> !ack_q)
    else $error("Read direction byte was acknowledged.");

  extra_nack_a: assert property (@(posedge scl_clk) disable iff (rst_l)
    (st_q == i2cw_pkg::ST_XTRA && byte_done) |=> !ack_q ##1 !ack_q)
    else $error("Byte beyond the fourth data byte was acknowledged.");

  commit_time_a: assert property (@(posedge scl_clk) disable iff (rst_l)
    $changed(cmt_tgl_q) |-> $past(last_q) && ($past(cnt_q) == i2cw_pkg::ACK_SLOT))
    else $error("Commit happened outside the fourth data acknowledge.");

  commit_valid_a: assert property (@(posedge scl_clk) disable iff (rst_l)
    $changed(cmt_tgl_q) |-> $past(cmd_ok) && (h_port_q <= i2cw_pkg::PORT_MAX))
    else $error("Invalid command was committed.");

  data_order_a: assert property (@(posedge scl_clk) disable iff (rst_l)
    $changed(cmt_tgl_q) |-> h_data_q[31:24] == dat_q[0] && h_data_q[7:0] == dat_q[3])
    else $error("Data bytes were not placed most significant first.");

  ack_drive_a: assert property (@(posedge scl_clk) disable iff (rst_l)
    (byte_done && ack_d) |=> (cnt_q == i2cw_pkg::ACK_SLOT) && oe_q ##1 !oe_q)
    else $error("Acknowledge was not driven for exactly the ack slot.");

  strobe_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    cmt_evt |=> wr_stb && wr_port <= i2cw_pkg::PORT_MAX ##1 !wr_stb)
    else $error("Write strobe missing, too long or for a bad port.");

  masked_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_stb && !wr_be[3] && rd_port == wr_port && rd_addr == wr_addr[i2cw_pkg::AW-1:2]
    |=> $stable(rd_data[31:24]))
    else $error("Disabled byte lane changed.");

endmodule

// [verilog/i2cw_sync.sv]
// Two-flop synchroniser for levels entering a clock domain.
module i2cw_sync #(
  parameter int W = 1
) (
  // Destination clock.
  input wire logic clk,
  // Asynchronous level in, synchronised level out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] sync_q
);

  logic [W-1:0] meta_q;

  // Data only: these flops settle from the input within two edges, so no reset.
  always_ff @(posedge clk) begin
    meta_q <= d;
    sync_q <= meta_q;
  end

endmodule
